// ### verilog/ups_regs.sv
/*
 Port status and configuration registers: transceiver control, status,
 trim and role select.
 Assumes CPU port, negotiation pulses and pins all synchronous to mclk.
*/
// Summary of operation
// - Operating mode 00 normal, 01 non-driving, 10 raw, 11 power-down.
// - Auto negotiation on: hardware loads the operating mode field.
// - Device status bit 7 mirrors the supply-sense pin, also in sleep.
// - Device status bit 6 is speed, 1 full; set by handshake.
// - Speed bit always readable, writable only while active.
// - Cable connection sets the speed bit to full speed.
// - HS termination: device line field reports bus activity.
// - FS termination: FS or HS receiver; SE0 00, J 01, K 10, SE1 11.
// - Device line field stays valid during sleep.
// - Host status bit 7 is the over-current pin inverted.
// - Host line: FS receiver at 01, LS at 11, activity at 00.
// - Host status stays valid during sleep.
// - Trim bits 5:4 set HS slew, 00 slowest to 11 fastest.
// - Trim bits 1:0 set HS termination, 00 highest to 11 lowest.
// - Role bit 0 stops host clock, 1 stops device clock.
`timescale 1ns/1ps
`default_nettype none

`include "ups_defines.svh"

module ups_regs
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    sys_rst,
   // CPU register port
   input  wire logic [ADDR_W-1:0]       reg_addr,
   input  wire logic [7:0]              reg_wr_data,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rd_data,
   // Power state
   input  wire logic                    active_state,
   // Negotiation logic
   input  wire logic                    dev_nego_load,
   input  wire ups_pkg::ups_xcvr_ctl_t  dev_nego_ctl,
   input  wire logic                    host_nego_load,
   input  wire ups_pkg::ups_xcvr_ctl_t  host_nego_ctl,
   input  wire logic                    speed_handshake_done,
   input  wire logic                    speed_handshake_fs,
   input  wire logic                    cable_connect,
   // Pins and receivers
   input  wire logic                    supply_sense_pin,
   input  wire logic                    overcurrent_flag_pin,
   input  wire ups_pkg::ups_rx_t        dev_rx,
   input  wire ups_pkg::ups_rx_t        host_rx,
   // Transceiver macro controls
   output ups_pkg::ups_xcvr_ctl_t       dev_xcvr,
   output ups_pkg::ups_xcvr_operating_mode_dec_t     dev_mode,
   output ups_pkg::ups_xcvr_ctl_t       host_xcvr,
   output ups_pkg::ups_xcvr_operating_mode_dec_t     host_mode,
   output ups_pkg::ups_trim_t           trim,
   output logic                         speed_full_not_high,
   // Clock gate enables
   output logic                         dev_clk_en,
   output logic                         host_clk_en
);
   import ups_pkg::*;

   generate
      if (ADDR_W < 8)
      begin : g_bad_addr
         $error("ups_regs: ADDR_W must be at least 8");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Operating mode decode

   function automatic ups_xcvr_operating_mode_dec_t decode_mode(input logic [1:0] code);
      ups_xcvr_operating_mode_dec_t d;
      d              = '0;
      d.normal       = (code == `UPS_OPM_NORMAL);
      d.non_driving  = (code == `UPS_OPM_NODRIVE);
      d.raw_no_stuff = (code == `UPS_OPM_RAW);
      d.power_down   = (code == `UPS_OPM_PWRDN);
      return d;
   endfunction

   function automatic ups_xcvr_ctl_t reg_to_ctl(input logic [7:0] r);
      return '{r[`UPS_TERM_BIT], r[`UPS_RPD_BIT],
               r[`UPS_XSEL_HI:`UPS_XSEL_LO], r[`UPS_OPM_HI:`UPS_OPM_LO]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register state

   ups_xcvr_ctl_t host_ctl;
   ups_xcvr_ctl_t dev_ctl;
   ups_trim_t     trim_reg;
   logic          dev_auto;
   logic          host_auto;
   logic          role_host_not_device;
   logic          speed_bit;
   logic          supply_level;
   logic          ovc_status;
   logic [1:0]    dev_line;
   logic [1:0]    host_line;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   wire sel_host_xcvr = (reg_addr == ADDR_W'(`UPS_ADDR_HOST_XCVR));
   wire sel_dev_stat  = (reg_addr == ADDR_W'(`UPS_ADDR_DEV_STAT));
   wire sel_host_stat = (reg_addr == ADDR_W'(`UPS_ADDR_HOST_STAT));
   wire sel_trim      = (reg_addr == ADDR_W'(`UPS_ADDR_TRIM));
   wire sel_dev_xcvr  = (reg_addr == ADDR_W'(`UPS_ADDR_DEV_XCVR));
   wire sel_nego      = (reg_addr == ADDR_W'(`UPS_ADDR_NEGO));
   wire sel_role      = (reg_addr == ADDR_W'(`UPS_ADDR_ROLE));

   wire wr_host_xcvr  = reg_wr && sel_host_xcvr;
   wire wr_dev_xcvr   = reg_wr && sel_dev_xcvr;
   wire wr_trim       = reg_wr && sel_trim;
   wire wr_nego       = reg_wr && sel_nego;
   wire wr_role       = reg_wr && sel_role;
   // Speed is only writable while active; a write in sleep is dropped
   wire wr_speed      = reg_wr && sel_dev_stat && active_state;

   ////////////////////////////////////////////////////////////////////////
   // Next values of the transceiver controls

   // Only documented fields are taken from a write
   ups_xcvr_ctl_t host_wr_ctl;
   ups_xcvr_ctl_t dev_wr_ctl;

   assign host_wr_ctl.term_fs      = reg_wr_data[`UPS_TERM_BIT];
   assign host_wr_ctl.pulldown_off = reg_wr_data[`UPS_RPD_BIT];
   assign host_wr_ctl.xcvr_sel     = reg_wr_data[`UPS_XSEL_HI:`UPS_XSEL_LO];
   assign host_wr_ctl.op_mode      = reg_wr_data[`UPS_OPM_HI:`UPS_OPM_LO];

   // Device side has a single-bit transceiver select and no pull-down
   assign dev_wr_ctl.term_fs       = reg_wr_data[`UPS_TERM_BIT];
   assign dev_wr_ctl.pulldown_off  = 1'b0;
   assign dev_wr_ctl.xcvr_sel      = {1'b0, reg_wr_data[`UPS_XSEL_LO]};
   assign dev_wr_ctl.op_mode       = reg_wr_data[`UPS_OPM_HI:`UPS_OPM_LO];

   // Hardware load wins over a software write in the same cycle
   wire dev_hw_load  = dev_auto && dev_nego_load;
   wire host_hw_load = host_auto && host_nego_load;

   ups_xcvr_ctl_t next_dev_ctl;
   ups_xcvr_ctl_t next_host_ctl;

   assign next_dev_ctl  = dev_hw_load  ? dev_nego_ctl  :
                          wr_dev_xcvr  ? dev_wr_ctl    : dev_ctl;
   assign next_host_ctl = host_hw_load ? host_nego_ctl :
                          wr_host_xcvr ? host_wr_ctl   : host_ctl;

   ////////////////////////////////////////////////////////////////////////
   // Next value of the speed bit

   // Cable connect has priority, then the handshake, then software
   logic next_speed;

   assign next_speed = cable_connect        ? `UPS_SPEED_FS      :
                       speed_handshake_done ? speed_handshake_fs :
                       wr_speed             ? reg_wr_data[`UPS_SPEED_BIT]
                                            : speed_bit;

   ////////////////////////////////////////////////////////////////////////
   // Line state selection

   logic [1:0] dev_line_sel;
   logic [1:0] host_line_sel;

   // Device: HS termination reports activity, else FS or HS receiver
   ups_line_sel u_dev_line
   (
      .report_activity (!dev_ctl.term_fs),
      .pick_first      (dev_ctl.xcvr_sel[0]),
      .force_idle      (1'b0),
      .first_line      (dev_rx.fs_line),
      .second_line     (dev_rx.hs_line),
      .activity        (dev_rx.bus_activity),
      .line_level      (dev_line_sel)
   );

   // Host: 00 activity, 01 FS receiver, 11 LS receiver, 10 reads idle
   ups_line_sel u_host_line
   (
      .report_activity (host_ctl.xcvr_sel == `UPS_XSEL_HS),
      .pick_first      (host_ctl.xcvr_sel == `UPS_XSEL_FS),
      .force_idle      (host_ctl.xcvr_sel[1] &&
                        !host_ctl.xcvr_sel[0]),
      .first_line      (host_rx.fs_line),
      .second_line     (host_rx.ls_line),
      .activity        (host_rx.bus_activity),
      .line_level      (host_line_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read data assembly

   logic [7:0] host_xcvr_rd;
   logic [7:0] dev_xcvr_rd;
   logic [7:0] dev_stat_rd;
   logic [7:0] host_stat_rd;
   logic [7:0] trim_rd;
   logic [7:0] nego_rd;
   logic [7:0] role_rd;
   logic [7:0] next_rd_data;

   always_comb
   begin
      host_xcvr_rd = `UPS_ZERO_BYTE;
      host_xcvr_rd[`UPS_TERM_BIT] = host_ctl.term_fs;
      host_xcvr_rd[`UPS_RPD_BIT] = host_ctl.pulldown_off;
      host_xcvr_rd[`UPS_XSEL_HI:`UPS_XSEL_LO] = host_ctl.xcvr_sel;
      host_xcvr_rd[`UPS_OPM_HI:`UPS_OPM_LO] = host_ctl.op_mode;

      dev_xcvr_rd = `UPS_ZERO_BYTE;
      dev_xcvr_rd[`UPS_TERM_BIT] = dev_ctl.term_fs;
      dev_xcvr_rd[`UPS_XSEL_LO] = dev_ctl.xcvr_sel[0];
      dev_xcvr_rd[`UPS_OPM_HI:`UPS_OPM_LO] = dev_ctl.op_mode;

      dev_stat_rd = `UPS_ZERO_BYTE;
      dev_stat_rd[`UPS_SUPPLY_BIT] = supply_level;
      dev_stat_rd[`UPS_SPEED_BIT] = speed_bit;
      dev_stat_rd[`UPS_LINE_HI:`UPS_LINE_LO] = dev_line;

      host_stat_rd = `UPS_ZERO_BYTE;
      host_stat_rd[`UPS_OVC_BIT] = ovc_status;
      host_stat_rd[`UPS_LINE_HI:`UPS_LINE_LO] = host_line;

      trim_rd = `UPS_ZERO_BYTE;
      trim_rd[`UPS_SLEW_HI:`UPS_SLEW_LO] = trim_reg.hs_slew_rate_trim;
      trim_rd[`UPS_TTRIM_HI:`UPS_TTRIM_LO] = trim_reg.hs_termination_trim;

      nego_rd = `UPS_ZERO_BYTE;
      nego_rd[`UPS_DEV_AUTO_BIT] = dev_auto;
      nego_rd[`UPS_HOST_AUTO_BIT] = host_auto;

      role_rd = `UPS_ZERO_BYTE;
      role_rd[`UPS_ROLE_BIT] = role_host_not_device;
   end

   // Unmapped addresses read as zero
   assign next_rd_data = !reg_rd       ? `UPS_ZERO_BYTE :
                         sel_host_xcvr ? host_xcvr_rd   :
                         sel_dev_xcvr  ? dev_xcvr_rd    :
                         sel_dev_stat  ? dev_stat_rd    :
                         sel_host_stat ? host_stat_rd   :
                         sel_trim      ? trim_rd        :
                         sel_nego      ? nego_rd        :
                         sel_role      ? role_rd        : `UPS_ZERO_BYTE;

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         host_ctl <= reg_to_ctl(`UPS_HOST_XCVR_RST);
         dev_ctl  <= reg_to_ctl(`UPS_DEV_XCVR_RST);
      end
      else
      begin
         host_ctl <= next_host_ctl;
         dev_ctl  <= next_dev_ctl;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         trim_reg             <= '0;
         dev_auto             <= 1'b0;
         host_auto            <= 1'b0;
         role_host_not_device <= 1'(`UPS_ROLE_RST >> `UPS_ROLE_BIT);
         speed_bit            <= `UPS_SPEED_RST;
      end
      else
      begin
         if (wr_trim)
         begin
            trim_reg.hs_slew_rate_trim   <=
               reg_wr_data[`UPS_SLEW_HI:`UPS_SLEW_LO];
            trim_reg.hs_termination_trim <=
               reg_wr_data[`UPS_TTRIM_HI:`UPS_TTRIM_LO];
         end
         if (wr_nego)
         begin
            dev_auto  <= reg_wr_data[`UPS_DEV_AUTO_BIT];
            host_auto <= reg_wr_data[`UPS_HOST_AUTO_BIT];
         end
         if (wr_role)
            role_host_not_device <= reg_wr_data[`UPS_ROLE_BIT];
         speed_bit <= next_speed;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status sampling

   // Sampled every cycle with no power-state gating, so the status stays
   // live in sleep; the cost is one cycle of latency on each pin
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         supply_level <= 1'b0;
         ovc_status   <= 1'b0;
         dev_line     <= `UPS_LINE_IDLE;
         host_line    <= `UPS_LINE_IDLE;
      end
      else
      begin
         supply_level <= supply_sense_pin;
         ovc_status   <= !overcurrent_flag_pin;
         dev_line     <= dev_line_sel;
         host_line    <= host_line_sel;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         reg_rd_data <= `UPS_ZERO_BYTE;
      else
         reg_rd_data <= next_rd_data;
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         dev_xcvr            <= reg_to_ctl(`UPS_DEV_XCVR_RST);
         host_xcvr           <= reg_to_ctl(`UPS_HOST_XCVR_RST);
         dev_mode            <= decode_mode(`UPS_OPM_NODRIVE);
         host_mode           <= decode_mode(`UPS_OPM_NODRIVE);
         trim                <= '0;
         speed_full_not_high <= `UPS_SPEED_RST;
         dev_clk_en          <= 1'b1;
         host_clk_en         <= 1'b0;
      end
      else
      begin
         dev_xcvr            <= dev_ctl;
         host_xcvr           <= host_ctl;
         dev_mode            <= decode_mode(dev_ctl.op_mode);
         host_mode           <= decode_mode(host_ctl.op_mode);
         trim                <= trim_reg;
         speed_full_not_high <= speed_bit;
         dev_clk_en          <= !role_host_not_device;
         host_clk_en         <= role_host_not_device;
      end
   end

endmodule

`default_nettype wire

// ### verilog/ups_defines.svh
/*
 Register offsets, field positions, reset values and codes of the USB port
 status and configuration slice.
 Assumes an 8-bit register address and 8-bit register data.
*/
`ifndef UPS_DEFINES_SVH
`define UPS_DEFINES_SVH

// Register offsets
`define UPS_ADDR_HOST_XCVR 8'h17
`define UPS_ADDR_DEV_STAT 8'h18
`define UPS_ADDR_HOST_STAT 8'h19
`define UPS_ADDR_TRIM 8'h1B
`define UPS_ADDR_DEV_XCVR 8'h1C
`define UPS_ADDR_NEGO 8'h1D
`define UPS_ADDR_ROLE 8'h1F

// Transceiver control fields (both sides)
`define UPS_TERM_BIT 7
`define UPS_RPD_BIT 6
`define UPS_XSEL_HI 5
`define UPS_XSEL_LO 4
`define UPS_OPM_HI 1
`define UPS_OPM_LO 0

// Status fields
`define UPS_SUPPLY_BIT 7
`define UPS_SPEED_BIT 6
`define UPS_OVC_BIT 7
`define UPS_LINE_HI 1
`define UPS_LINE_LO 0

// Trim fields
`define UPS_SLEW_HI 5
`define UPS_SLEW_LO 4
`define UPS_TTRIM_HI 1
`define UPS_TTRIM_LO 0

// Negotiation and role fields
`define UPS_DEV_AUTO_BIT 0
`define UPS_HOST_AUTO_BIT 1
`define UPS_ROLE_BIT 0

// Reset values
`define UPS_HOST_XCVR_RST 8'h91
`define UPS_DEV_XCVR_RST 8'h91
`define UPS_ROLE_RST 8'h00
`define UPS_SPEED_RST 1'h1
`define UPS_ZERO_BYTE 8'h00

// Operating mode codes
`define UPS_OPM_NORMAL 2'h0
`define UPS_OPM_NODRIVE 2'h1
`define UPS_OPM_RAW 2'h2
`define UPS_OPM_PWRDN 2'h3

// Transceiver select codes (host side)
`define UPS_XSEL_HS 2'h0
`define UPS_XSEL_FS 2'h1
`define UPS_XSEL_LS 2'h3

// Line state while reporting bus activity
`define UPS_LINE_IDLE 2'h0
`define UPS_LINE_BUSY 2'h1

// Speed bit values
`define UPS_SPEED_FS 1'h1

`endif

// ### verilog/ups_pkg.sv
/*
 Types shared by the USB port status and configuration slice.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ups_pkg;

   // Transceiver control as seen by the macro
   typedef struct packed {
      logic       term_fs;
      logic       pulldown_off;
      logic [1:0] xcvr_sel;
      logic [1:0] op_mode;
   } ups_xcvr_ctl_t;

   // Decoded operating mode
   typedef struct packed {
      logic normal;
      logic non_driving;
      logic raw_no_stuff;
      logic power_down;
   } ups_xcvr_operating_mode_dec_t;

   // Transceiver trim values
   typedef struct packed {
      logic [1:0] hs_slew_rate_trim;
      logic [1:0] hs_termination_trim;
   } ups_trim_t;

   // Receiver values from the macro
   typedef struct packed {
      logic [1:0] hs_line;
      logic [1:0] fs_line;
      logic [1:0] ls_line;
      logic       bus_activity;
   } ups_rx_t;

endpackage

// ### verilog/ups_line_sel.sv
/*
 Line state selector: picks a receiver value or reports bus activity.
 Assumes receiver values already arrive synchronous to the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

`include "ups_defines.svh"

module ups_line_sel
(
   // Selection
   input  wire logic       report_activity,
   input  wire logic       pick_first,
   input  wire logic       force_idle,
   // Receivers
   input  wire logic [1:0] first_line,
   input  wire logic [1:0] second_line,
   input  wire logic       activity,
   // Result
   output logic      [1:0] line_level
);

   wire [1:0] activity_code;
   wire [1:0] decoded_code;

   assign activity_code = activity ? `UPS_LINE_BUSY : `UPS_LINE_IDLE;
   assign decoded_code  = pick_first ? first_line : second_line;
   // Reserved select codes read as idle rather than as a stale receiver
   assign line_level    = force_idle      ? `UPS_LINE_IDLE :
                          report_activity ? activity_code  : decoded_code;

endmodule

`default_nettype wire

// ### verif/ups_partner.sv
/*
 Cable and transceiver model: one line condition seen by the FS, LS and
 HS receivers of a port.
 Assumes the bench changes the line condition away from clock edges.
*/
`timescale 1ns/1ps
`default_nettype none
module ups_partner
   import ups_pkg::*;
(
   // Cable condition, SE0 00, J 01, K 10, SE1 11
   input  wire logic [1:0] line_code,
   input  wire logic       activity,
   // Receivers
   output var  ups_rx_t    rx
);
   // LS signalling swaps J and K on the same wires
   assign rx.fs_line      = line_code;
   assign rx.ls_line      = {line_code[0], line_code[1]};
   // Squelch keeps the HS receiver at SE0 without activity
   assign rx.hs_line      = activity ? line_code : 2'h0;
   assign rx.bus_activity = activity;
endmodule
`default_nettype wire

// ### verif/ups_assertions.sv
/*
 Checker of the port status slice, bound to ups_regs.
 Assumes pins held steady around reads.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ups_defines.svh"
module ups_assertions
   import ups_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic              mclk,
   input wire logic              sys_rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wr_data,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rd_data,
   // Events and pins
   input wire logic              active_state,
   input wire logic              dev_nego_load,
   input wire logic              speed_handshake_done,
   input wire logic              speed_handshake_fs,
   input wire logic              cable_connect,
   input wire logic              supply_sense_pin,
   input wire logic              overcurrent_flag_pin,
   // Controls
   input wire ups_xcvr_ctl_t     dev_xcvr,
   input wire ups_xcvr_operating_mode_dec_t   dev_mode,
   input wire ups_xcvr_ctl_t     host_xcvr,
   input wire ups_xcvr_operating_mode_dec_t   host_mode,
   input wire ups_trim_t         trim,
   input wire logic              speed_full_not_high,
   input wire logic              dev_clk_en,
   input wire logic              host_clk_en
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   wire       hw_speed = cable_connect | speed_handshake_done;
   wire       rd_dev   = reg_rd && reg_addr == `UPS_ADDR_DEV_STAT;
   wire       rd_host  = reg_rd && reg_addr == `UPS_ADDR_HOST_STAT;
   wire       wr_dxc   = reg_wr && reg_addr == `UPS_ADDR_DEV_XCVR;
   wire       wr_speed = reg_wr && reg_addr == `UPS_ADDR_DEV_STAT;
   wire       wr_trim  = reg_wr && reg_addr == `UPS_ADDR_TRIM;
   wire       wr_role  = reg_wr && reg_addr == `UPS_ADDR_ROLE;
   wire [3:0] dev_dec  = 4'h8 >> dev_xcvr.op_mode;
   wire [3:0] host_dec = 4'h8 >> host_xcvr.op_mode;
   //////////////////////////////////////////////////////////////////////
   a_mode_decode:
      assert property (dev_mode == dev_dec && host_mode == host_dec)
      else $error("mode decode");
   a_manual_mode:
      assert property (wr_dxc && !dev_nego_load |-> ##2
                       dev_xcvr.op_mode == $past(reg_wr_data[1:0], 2))
      else $error("manual mode lost");
   a_supply_bit:
      assert property (rd_dev |=> reg_rd_data[7] == $past(supply_sense_pin, 2))
      else $error("supply bit wrong");
   a_speed_read:
      assert property (rd_dev |=> reg_rd_data[6] == speed_full_not_high)
      else $error("speed read");
   a_handshake_set:
      assert property (speed_handshake_done && !cable_connect |-> ##2
                       speed_full_not_high == $past(speed_handshake_fs, 2))
      else $error("handshake lost");
   a_sleep_write:
      assert property (wr_speed && !active_state && !hw_speed |-> ##2
                       $stable(speed_full_not_high))
      else $error("speed written in sleep");
   a_cable_full:
      assert property (cable_connect |-> ##2 speed_full_not_high)
      else $error("cable not full speed");
   a_host_flag:
      assert property (rd_host |=>
                       reg_rd_data[7] == !$past(overcurrent_flag_pin, 2))
      else $error("host flag wrong");
   a_host_reserved:
      assert property (rd_host |=> reg_rd_data[6:2] == 5'h00)
      else $error("host reserved set");
   a_trim_write:
      assert property (wr_trim |-> ##2 trim == {$past(reg_wr_data[5:4], 2),
                                               $past(reg_wr_data[1:0], 2)})
      else $error("trim output wrong");
   a_role_gate:
      assert property (wr_role |-> ##2 dev_clk_en == !host_clk_en &&
                       host_clk_en == $past(reg_wr_data[0], 2))
      else $error("clock enables wrong");
endmodule
bind ups_regs ups_assertions #(.ADDR_W(ADDR_W)) i_ups_assertions (
   .mclk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
   .reg_rd_data, .active_state, .dev_nego_load, .cable_connect,
   .speed_handshake_done, .speed_handshake_fs, .supply_sense_pin,
   .overcurrent_flag_pin, .dev_xcvr, .dev_mode, .host_xcvr,
   .host_mode, .trim, .speed_full_not_high, .dev_clk_en,
   .host_clk_en);
`default_nettype wire

// ### verif/test_ups_regs.sv
/*
 Bench of the port status slice: register tasks, pins, two cable models.
 Assumes design, package, model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ups_defines.svh"
`define CHK(n, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("unexpected %s exp %h got %h", n, e, g); \
      end \
   end
module test_ups_regs;
   import ups_pkg::*;
   logic            mclk = 1'b0;
   logic            sys_rst, reg_wr, reg_rd, active_state, dev_nego_load;
   logic            speed_handshake_done, speed_handshake_fs, cable_connect;
   logic            supply_sense_pin, overcurrent_flag_pin, act, host_load;
   logic [7:0]      reg_addr, reg_wr_data, reg_rd_data;
   logic [1:0]      line;
   ups_xcvr_ctl_t   dev_nego_ctl, dev_xcvr, host_xcvr;
   ups_xcvr_operating_mode_dec_t dev_mode, host_mode;
   ups_trim_t       trim;
   ups_rx_t         dev_rx, host_rx;
   logic            speed_full_not_high, dev_clk_en, host_clk_en;
   int              err_count, comparisons, cycles;
   logic [7:0]      rst_addr [6] = '{`UPS_ADDR_HOST_XCVR, `UPS_ADDR_DEV_XCVR,
                       `UPS_ADDR_TRIM, `UPS_ADDR_NEGO, `UPS_ADDR_ROLE, 8'h1A};
   logic [7:0]      rst_val [6]  = '{8'h91, 8'h91, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0]      dcfg [3]     = '{8'h91, 8'h81, 8'h01};
   // Host select codes 01, 11, 00; the reserved code is never used
   logic [7:0]      hcfg [3]     = '{8'h90, 8'hB0, 8'h00};
   ups_regs i_ups_regs (
      .mclk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr, .reg_rd,
      .reg_rd_data, .active_state, .dev_nego_load, .dev_nego_ctl,
      .host_nego_load(host_load), .host_nego_ctl(dev_nego_ctl),
      .speed_handshake_done, .speed_handshake_fs, .cable_connect,
      .supply_sense_pin, .overcurrent_flag_pin, .dev_rx, .host_rx,
      .dev_xcvr, .dev_mode, .host_xcvr, .host_mode, .trim,
      .speed_full_not_high, .dev_clk_en, .host_clk_en);
   ups_partner i_ups_partner_dev (.line_code(line), .activity(act),
      .rx(dev_rx));
   ups_partner i_ups_partner_host (.line_code(line), .activity(act),
      .rx(host_rx));
   always #25 mclk = ~mclk;
   //////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr      <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // Mask keeps only the fields under test
   task automatic rd(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_rd_data", e, reg_rd_data & m)
   endtask
   task automatic speed_event(input logic cab, input logic fs);
      @(posedge mclk);
      cable_connect        <= cab;
      speed_handshake_done <= !cab;
      speed_handshake_fs   <= fs;
      @(posedge mclk);
      cable_connect        <= 1'b0;
      speed_handshake_done <= 1'b0;
   endtask
   function automatic logic [1:0] dexp(int k, logic [1:0] c);
      if (k == 2)
         return {1'b0, c[0]};
      return (k == 0 || c[0]) ? c : 2'h0;
   endfunction
   function automatic logic [1:0] hexp(int k, logic [1:0] c);
      if (k == 0)
         return c;
      return (k == 1) ? {c[0], c[1]} : {1'b0, c[0]};
   endfunction
   task automatic tally_and_finish;
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      {reg_wr, reg_rd, dev_nego_load, host_load, cable_connect} = 5'h00;
      {speed_handshake_done, speed_handshake_fs, act} = 3'h0;
      {supply_sense_pin, overcurrent_flag_pin, line} = 4'h0;
      {reg_addr, reg_wr_data, dev_nego_ctl} = 22'h000000;
      active_state = 1'b1;
      sys_rst      = 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++)
         rd(rst_addr[i], 8'hFF, rst_val[i]);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h40);
      `CHK("clk_en", 6'h20, {dev_clk_en, host_clk_en, trim})
      for (int v = 0; v < 4; v++)
      begin
         wr(`UPS_ADDR_TRIM, {2'h3, v[1:0], 2'h3, ~v[1:0]});
         rd(`UPS_ADDR_TRIM, 8'hFF, {2'h0, v[1:0], 2'h0, ~v[1:0]});
         `CHK("trim", {v[1:0], ~v[1:0]}, trim)
         wr(`UPS_ADDR_DEV_XCVR, 8'h90 | v[7:0]);
         wr(`UPS_ADDR_HOST_XCVR, 8'h90 | v[7:0]);
         tick(1);
         `CHK("dev_mode", 4'h8 >> v, dev_mode)
         `CHK("host_mode", 4'h8 >> v, host_mode)
      end
      wr(`UPS_ADDR_NEGO, 8'h01);
      for (int j = 0; j < 2; j++)
      begin
         dev_nego_ctl  <= j ? 6'h12 : 6'h23;
         dev_nego_load <= 1'b1;
         tick(1);
         dev_nego_load <= 1'b0;
         wr(`UPS_ADDR_NEGO, 8'h00);
         rd(`UPS_ADDR_DEV_XCVR, 8'hFF, 8'h83);
      end
      // Sleep until active_state is set again: status must stay live
      active_state <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         if (i % 4 == 0)
         begin
            wr(`UPS_ADDR_DEV_XCVR, dcfg[i / 4]);
            wr(`UPS_ADDR_HOST_XCVR, hcfg[i / 4]);
         end
         line                 <= i[1:0];
         act                  <= i[0];
         supply_sense_pin     <= i[1];
         overcurrent_flag_pin <= i[1];
         tick(2);
         rd(`UPS_ADDR_DEV_STAT, 8'hBF, {i[1], 5'h00, dexp(i / 4, i[1:0])});
         rd(`UPS_ADDR_HOST_STAT, 8'hFF, {!i[1], 5'h00, hexp(i / 4, i[1:0])});
      end
      wr(`UPS_ADDR_HOST_STAT, 8'hFF);
      rd(`UPS_ADDR_HOST_STAT, 8'h7F, 8'h01);
      wr(`UPS_ADDR_DEV_STAT, 8'h00);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h40);
      active_state <= 1'b1;
      wr(`UPS_ADDR_DEV_STAT, 8'h00);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h00);
      speed_event(1'b1, 1'b0);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h40);
      speed_event(1'b0, 1'b0);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h00);
      speed_event(1'b0, 1'b1);
      rd(`UPS_ADDR_DEV_STAT, 8'h40, 8'h40);
      wr(`UPS_ADDR_ROLE, 8'hFF);
      rd(`UPS_ADDR_ROLE, 8'hFF, 8'h01);
      `CHK("clk_en", 2'h1, {dev_clk_en, host_clk_en})
      wr(`UPS_ADDR_ROLE, 8'hFE);
      rd(`UPS_ADDR_ROLE, 8'hFF, 8'h00);
      `CHK("clk_en", 2'h2, {dev_clk_en, host_clk_en})
      tally_and_finish();
   end
endmodule
`default_nettype wire
